// file: uier_cfg.svh
/*
 Offsets, bit positions, reset values and bus codes of the register bank.
 Assumes it is included once per file by its bare name.
*/
`ifndef UIER_CFG_SVH
`define UIER_CFG_SVH
`define UIER_OFF_EV_EN 8'h00
`define UIER_OFF_ERR_FLAGS 8'h04
`define UIER_OFF_ERR_EN 8'h08
`define UIER_OFF_MODE 8'h0c
`define UIER_OFF_EV_FLAGS 8'h10
`define UIER_EP_BASE 2'b01
`define UIER_BIT_STALL_EV 7
`define UIER_BIT_ATTACH 6
`define UIER_BIT_SUMMARY 1
`define UIER_BIT_UNIMPL 6
`define UIER_BIT_HOST 0
`define UIER_EP_LOW_SPEED_DIRECT 7
`define UIER_EP_RETRY 6
`define UIER_EP_HOST_MASK 8'hc0
`define UIER_EP_IMPL_MASK 8'h1f
`define UIER_ERR_IMPL_MASK 8'hbf
`define UIER_EV_DEV_MASK 8'hbf
`define UIER_RST_BYTE 8'h00
`define UIER_RST_WORD 32'h0000_0000
`define UIER_RESP_OKAY 2'b00
`define UIER_RESP_SLVERR 2'b10
`endif

// file: uier_engine_model.sv
/*
 Packet engine stand-in: error pulses and stall reports on request.
 Assumes the bench calls its tasks and shares the bank clock.
*/
`timescale 1ns/1ps
`default_nettype none
module uier_engine_model (
  input wire logic aclk,
  output var uier_pkg::uier_err_in_t err_in,
  output logic stall_sent,
  output logic [3:0] stall_ep
);
  import uier_pkg::*;
  // ********************
  // Stimulus
  // ********************
  // Quiet lines at time zero
  initial begin
    err_in = '0;
    stall_sent = 1'h0;
    stall_ep = 4'h0;
  end
  // One-cycle error pulse
  task automatic hit(input uier_err_in_t e);
    @(posedge aclk);
    err_in <= e;
    @(posedge aclk);
    err_in <= '0;
  endtask
  // One-cycle stall report; the index is scrambled once it ends
  task automatic stall(input logic [3:0] n);
    @(posedge aclk);
    stall_sent <= 1'h1;
    stall_ep <= n;
    @(posedge aclk);
    stall_sent <= 1'h0;
    stall_ep <= ~n;
  endtask
endmodule
`default_nettype wire

// file: uier_ep_mem.sv
/*
 Sixteen endpoint control bytes with registered read ports.
 Assumes one synchronous active-low reset and writes pre-masked by the caller.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uier_cfg.svh"
module uier_ep_mem (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic we,
  input wire logic [3:0] waddr,
  input wire logic [7:0] wdata,
  input wire logic stall_set,
  input wire logic [3:0] stall_idx,
  input wire logic [3:0] bus_raddr,
  output logic [7:0] bus_rdata,
  input wire logic [3:0] look_raddr,
  output logic [7:0] look_rdata,
  output logic [7:0] ep0
);
  logic [7:0] mem [16];

  // Writes; a stall report wins over a clearing write
  always_ff @(posedge aclk) begin
    for (int i = 0; i < 16; i++) begin
      if (!aresetn) begin
        mem[i] <= `UIER_RST_BYTE;
      end else begin
        if (we && waddr == 4'(i)) begin
          mem[i] <= wdata;
        end
        if (stall_set && stall_idx == 4'(i)) begin
          mem[i][1] <= 1'b1;
        end
      end
    end
  end

  // Registered read ports
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      bus_rdata <= `UIER_RST_BYTE;
      look_rdata <= `UIER_RST_BYTE;
      ep0 <= `UIER_RST_BYTE;
    end else begin
      bus_rdata <= mem[bus_raddr];
      look_rdata <= mem[look_raddr];
      ep0 <= mem[0];
    end
  end
endmodule
`default_nettype wire

// file: uier_err_flags.sv
/*
 Sticky error flags, set by hardware and cleared by writing ones.
 Assumes set pulses are already steered for the current mode.
*/
`timescale 1ns/1ps
`default_nettype none
`include "uier_cfg.svh"
module uier_err_flags (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] set,
  input wire logic clr_we,
  input wire logic [7:0] clr_data,
  output logic [7:0] flags
);
  logic [7:0] clr;

  assign clr = clr_we ? clr_data : `UIER_RST_BYTE;

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      flags <= `UIER_RST_BYTE;
    end else begin
      flags <= ((flags & ~clr) | set) & `UIER_ERR_IMPL_MASK;
    end
  end
endmodule
`default_nettype wire

// file: uier_pkg.sv
/*
 Types of the register bank: hardware error events and endpoint fields.
 Assumes the header uier_cfg.svh is used for all numbers.
*/
package uier_pkg;
  // Error events from the packet engine, one-cycle pulses
  typedef struct packed {
    logic stuffing;
    logic timeout;
    logic alignment;
    logic data_crc;
    logic token_crc;
    logic frame_end;
    logic packet_id;
  } uier_err_in_t;
  // Endpoint control byte
  typedef struct packed {
    logic low_speed_direct;
    logic nak_retry_disable;
    logic spare;
    logic setup_transfer_disable;
    logic endpoint_rx_enable;
    logic endpoint_tx_enable;
    logic endpoint_stalled;
    logic endpoint_handshake_enable;
  } uier_ep_t;
  typedef enum logic [2:0] {
    UIER_R_EV_EN, UIER_R_ERR_FLAGS, UIER_R_ERR_EN, UIER_R_MODE,
    UIER_R_EV_FLAGS, UIER_R_EP, UIER_R_NONE
  } uier_reg_t;
  typedef enum logic [1:0] {UIER_RD_IDLE, UIER_RD_FETCH, UIER_RD_RESP} uier_rd_t;
endpackage

// file: uier_regs.sv
/*
 USB interrupt enable, error flag, error enable and endpoint control registers
 behind an AXI4-Lite slave, with endpoint lookup and interrupt request.
 Assumes the packet engine supplies error pulses and event flag levels on aclk.
*/
// Local design decisions: register access over AXI4-Lite and the placing of the registers.
`timescale 1ns/1ps
`default_nettype none
`include "uier_cfg.svh"
// How it works
// - Event enable low byte gates events; bit 7 stall; upper byte zero.
// - Attach enable bit 6 exists only in host mode, else reads zero.
// - Bit 0 enables bus reset in device mode, detach in host mode.
// - Bit stuffing violation sets flag bit 7.
// - Too many received bytes set flag bit 5 and extra bytes are dropped.
// - Missing turnaround response sets flag bit 4.
// - Data field not whole bytes sets flag bit 3.
// - Data packet CRC16 failure sets flag bit 2.
// - Device mode: token CRC5 rejection sets flag bit 1.
// - Host mode: end-of-frame error sets flag bit 1.
// - Packet identifier check failure sets flag bit 0.
// - Flags clear only where a written word carries a one.
// - Error enables mirror flag layout; bit 6 reads zero.
// - Error enable bit 1 gates CRC5 in device, EOF in host mode.
// - Sixteen endpoint control registers, low byte only.
// - With rx and tx both on, bit 4 blocks SETUP transfers.
// - Bit 3 permits receive, bit 2 permits transmit.
// - Bit 1 reads one once the endpoint was stalled.
// - Bit 0 enables handshake packets.
// - Endpoint zero bit 7 enables low-speed direct connection.
// - Endpoint zero bit 6 disables hardware NAK retry.
// - Bits 7 and 6 exist only on endpoint zero in host mode.
// - Summary error flag comes only from enabled error flags.
module uier_regs (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  input wire uier_pkg::uier_err_in_t err_in,
  input wire logic [7:0] event_flags,
  input wire logic rx_byte_strobe,
  input wire logic [9:0] rx_byte_index,
  input wire logic [9:0] bd_byte_count,
  output logic rx_store_enable,
  input wire logic [3:0] ep_sel,
  output logic ep_rx_allowed,
  output logic ep_tx_allowed,
  output logic ep_setup_allowed,
  output logic ep_handshake,
  input wire logic stall_sent,
  input wire logic [3:0] stall_ep,
  output logic low_speed_direct,
  output logic nak_retry_disable,
  output logic [7:0] event_enable_eff,
  output logic error_summary_flag,
  output logic usb_irq
);
  import uier_pkg::*;

  // ****************************************
  // Address decode
  // ****************************************

  // Map a byte address to a register
  function automatic uier_reg_t decode(input logic [7:0] a);
    uier_reg_t r;
    r = UIER_R_NONE;
    if (a[7:6] == `UIER_EP_BASE && a[1:0] == 2'b00) begin
      r = UIER_R_EP;
    end else begin
      case (a)
        `UIER_OFF_EV_EN: r = UIER_R_EV_EN;
        `UIER_OFF_ERR_FLAGS: r = UIER_R_ERR_FLAGS;
        `UIER_OFF_ERR_EN: r = UIER_R_ERR_EN;
        `UIER_OFF_MODE: r = UIER_R_MODE;
        `UIER_OFF_EV_FLAGS: r = UIER_R_EV_FLAGS;
        default: r = UIER_R_NONE;
      endcase
    end
    return r;
  endfunction

  logic [7:0] ev_en;
  logic [7:0] err_en;
  logic host_mode;
  logic [7:0] err_flags;
  logic [7:0] err_set;
  logic [7:0] ep_bus_data;
  uier_ep_t ep_look;
  uier_ep_t ep_zero;
  logic [7:0] aw_addr;
  logic aw_held;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic w_held;
  logic do_write;
  uier_reg_t wr_reg;
  logic lane0;
  logic [7:0] ep_wdata;
  uier_rd_t rd_state;
  uier_reg_t rd_reg;
  logic [7:0] rd_addr;
  logic [3:0] ep_raddr;
  logic [7:0] rd_byte;
  logic overrun;

  // ****************************************
  // Write channel
  // ****************************************

  assign s_axi_awready = !aw_held;
  assign s_axi_wready = !w_held;
  assign do_write = aw_held && w_held && !s_axi_bvalid;
  assign wr_reg = decode(aw_addr);
  assign lane0 = w_strb[0];

  // Hold the write address until both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held <= 1'b0;
      aw_addr <= `UIER_RST_BYTE;
    end else if (s_axi_awvalid && s_axi_awready) begin
      aw_held <= 1'b1;
      aw_addr <= s_axi_awaddr;
    end else if (do_write) begin
      aw_held <= 1'b0;
    end
  end

  // Hold the write data until both halves are in
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      w_held <= 1'b0;
      w_data <= `UIER_RST_WORD;
      w_strb <= 4'h0;
    end else if (s_axi_wvalid && s_axi_wready) begin
      w_held <= 1'b1;
      w_data <= s_axi_wdata;
      w_strb <= s_axi_wstrb;
    end else if (do_write) begin
      w_held <= 1'b0;
    end
  end

  // Write response, error for unmapped addresses
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp <= `UIER_RESP_OKAY;
    end else if (do_write) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp <= (wr_reg == UIER_R_NONE) ? `UIER_RESP_SLVERR : `UIER_RESP_OKAY;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  // ****************************************
  // Enable and mode registers
  // ****************************************

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      ev_en <= `UIER_RST_BYTE;
    end else if (do_write && lane0 && wr_reg == UIER_R_EV_EN) begin
      ev_en <= w_data[7:0];
    end
  end

  // error enables, bit 6 kept zero
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      err_en <= `UIER_RST_BYTE;
    end else if (do_write && lane0 && wr_reg == UIER_R_ERR_EN) begin
      err_en <= w_data[7:0] & `UIER_ERR_IMPL_MASK;
    end
  end

  // Role select: host when set
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      host_mode <= 1'b0;
    end else if (do_write && lane0 && wr_reg == UIER_R_MODE) begin
      host_mode <= w_data[`UIER_BIT_HOST];
    end
  end

  // attach enable hidden in device mode
  // bit 0 serves reset or detach by role
  assign event_enable_eff = host_mode ? ev_en : (ev_en & `UIER_EV_DEV_MASK);

  // ****************************************
  // Error flags
  // ****************************************

  assign overrun = rx_byte_strobe && (rx_byte_index >= bd_byte_count);
  assign rx_store_enable = rx_byte_strobe && !overrun;

  assign err_set = {err_in.stuffing, 1'b0, overrun, err_in.timeout,
                    err_in.alignment, err_in.data_crc,
                    host_mode ? err_in.frame_end : err_in.token_crc,
                    err_in.packet_id};

  uier_err_flags u_flags (
    .aclk(aclk),
    .aresetn(aresetn),
    .set(err_set),
    .clr_we(do_write && lane0 && wr_reg == UIER_R_ERR_FLAGS),
    .clr_data(w_data[7:0]),
    .flags(err_flags)
  );

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      error_summary_flag <= 1'b0;
    end else begin
      error_summary_flag <= |(err_flags & err_en);
    end
  end

  // request held while flag and enable meet
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      usb_irq <= 1'b0;
    end else begin
      usb_irq <= |({event_flags[7:2], error_summary_flag, event_flags[0]}
                   & event_enable_eff);
    end
  end

  // ****************************************
  // Endpoint registers
  // ****************************************

  // host-only bits kept on endpoint zero in host mode
  always_comb begin
    ep_wdata = w_data[7:0] & `UIER_EP_IMPL_MASK;
    if (host_mode && aw_addr[5:2] == 4'h0) begin
      ep_wdata = w_data[7:0] & (`UIER_EP_IMPL_MASK | `UIER_EP_HOST_MASK);
    end
  end

  // sixteen bytes; stall sets bit 1
  uier_ep_mem u_ep (
    .aclk(aclk),
    .aresetn(aresetn),
    .we(do_write && lane0 && wr_reg == UIER_R_EP),
    .waddr(aw_addr[5:2]),
    .wdata(ep_wdata),
    .stall_set(stall_sent),
    .stall_idx(stall_ep),
    .bus_raddr(ep_raddr),
    .bus_rdata(ep_bus_data),
    .look_raddr(ep_sel),
    .look_rdata(ep_look),
    .ep0(ep_zero)
  );

  assign ep_rx_allowed = ep_look.endpoint_rx_enable;
  assign ep_tx_allowed = ep_look.endpoint_tx_enable;
  // setup allowed only when both directions on and bit 4 clear
  assign ep_setup_allowed = ep_look.endpoint_rx_enable && ep_look.endpoint_tx_enable
                            && !ep_look.setup_transfer_disable;
  assign ep_handshake = ep_look.endpoint_handshake_enable;
  assign low_speed_direct = host_mode && ep_zero.low_speed_direct;
  assign nak_retry_disable = host_mode && ep_zero.nak_retry_disable;

  // ****************************************
  // Read channel
  // ****************************************

  assign s_axi_arready = (rd_state == UIER_RD_IDLE);
  assign rd_reg = decode(rd_addr);
  // Endpoint read address follows the bus while idle, so the byte is ready at fetch
  assign ep_raddr = (rd_state == UIER_RD_IDLE) ? s_axi_araddr[5:2] : rd_addr[5:2];

  // Read data byte for the held address
  always_comb begin
    case (rd_reg)
      UIER_R_EV_EN: rd_byte = event_enable_eff;
      UIER_R_ERR_FLAGS: rd_byte = err_flags;
      UIER_R_ERR_EN: rd_byte = err_en;
      UIER_R_MODE: rd_byte = {7'h00, host_mode};
      UIER_R_EV_FLAGS: rd_byte = {event_flags[7:2], error_summary_flag, event_flags[0]};
      // host bits hidden outside host mode
      UIER_R_EP: rd_byte = host_mode ? ep_bus_data : (ep_bus_data & `UIER_EP_IMPL_MASK);
      default: rd_byte = `UIER_RST_BYTE;
    endcase
  end

  // Take address, wait for memory, answer
  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      rd_state <= UIER_RD_IDLE;
      rd_addr <= `UIER_RST_BYTE;
      s_axi_rvalid <= 1'b0;
      s_axi_rdata <= `UIER_RST_WORD;
      s_axi_rresp <= `UIER_RESP_OKAY;
    end else begin
      case (rd_state)
        UIER_RD_IDLE: begin
          if (s_axi_arvalid) begin
            rd_addr <= s_axi_araddr;
            rd_state <= UIER_RD_FETCH;
          end
        end
        UIER_RD_FETCH: begin
          s_axi_rdata <= {24'h000000, rd_byte};
          s_axi_rresp <= (rd_reg == UIER_R_NONE) ? `UIER_RESP_SLVERR : `UIER_RESP_OKAY;
          s_axi_rvalid <= 1'b1;
          rd_state <= UIER_RD_RESP;
        end
        UIER_RD_RESP: begin
          if (s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
            rd_state <= UIER_RD_IDLE;
          end
        end
        default: rd_state <= UIER_RD_IDLE;
      endcase
    end
  end
endmodule
`default_nettype wire

// file: uier_regs_bench.sv
/*
 Self-checking bench of the USB register bank over AXI4-Lite.
 Assumes the engine model and the port checker beside it.
*/
`timescale 1ns/1ps
`default_nettype none
module uier_regs_bench;
  import uier_pkg::*;
  // ********************
  // Signals and wiring
  // ********************
  logic aclk = 1'h0;
  logic aresetn = 1'h0;
  logic awvalid = 1'h0, wvalid = 1'h0, bready = 1'h0, arvalid = 1'h0, rready = 1'h0;
  logic strobe = 1'h0;
  logic [7:0] awaddr = 8'h00, araddr = 8'h00, ev = 8'h00, eff;
  logic [31:0] wdata = 32'h0, rdata;
  logic [3:0] wstrb = 4'hf, sel = 4'h0, sep;
  logic [9:0] idx = 10'h0, cnt = 10'h0;
  logic [1:0] bresp, rresp;
  logic awready, wready, bvalid, arready, rvalid, rxok, okrx, oktx, oksu, hs;
  logic lsd, nrd, summ, irq, ssent;
  uier_err_in_t err;
  logic [7:0] fb [7] = '{8'h01, 8'h02, 8'h02, 8'h04, 8'h08, 8'h10, 8'h80};
  logic [7:0] ra [6] = '{8'h00, 8'h04, 8'h08, 8'h0c, 8'h40, 8'h7c};
  logic [7:0] epv [4] = '{8'h1d, 8'h0c, 8'h04, 8'h18};
  logic [3:0] epx [4] = '{4'hd, 4'he, 4'h4, 4'h8};
  int mismatches = 0;
  int n_compared = 0;
  always #20 aclk = ~aclk;
  uier_regs dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr),
    .s_axi_awvalid(awvalid), .s_axi_awready(awready), .s_axi_wdata(wdata),
    .s_axi_wstrb(wstrb), .s_axi_wvalid(wvalid), .s_axi_wready(wready),
    .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
    .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready),
    .s_axi_rdata(rdata), .s_axi_rresp(rresp), .s_axi_rvalid(rvalid),
    .s_axi_rready(rready), .err_in(err), .event_flags(ev), .rx_byte_strobe(strobe),
    .rx_byte_index(idx), .bd_byte_count(cnt), .rx_store_enable(rxok), .ep_sel(sel),
    .ep_rx_allowed(okrx), .ep_tx_allowed(oktx), .ep_setup_allowed(oksu),
    .ep_handshake(hs), .stall_sent(ssent), .stall_ep(sep), .low_speed_direct(lsd),
    .nak_retry_disable(nrd), .event_enable_eff(eff), .error_summary_flag(summ),
    .usb_irq(irq));
  uier_engine_model eng_u (.aclk(aclk), .err_in(err), .stall_sent(ssent), .stall_ep(sep));
  // ********************
  // Tasks
  // ********************
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    n_compared++;
    if (got !== exp) begin
      mismatches++;
      $display("BAD %0t got %h exp %h", $time, got, exp);
    end
  endtask
  task automatic tally_and_finish;
    if (mismatches == 0 && n_compared > 0) begin
      $display("ALL CHECKS OK");
    end else begin
      $display("CHECKS NOT OK");
    end
    $finish;
  endtask
  // Write one word; readies are sampled mid-cycle, released after the edge
  task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = 2'h0,
      input logic [3:0] s = 4'hf);
    logic at, wt, bt;
    logic [1:0] r;
    @(posedge aclk);
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'h1;
    wvalid <= 1'h1;
    bready <= 1'h1;
    repeat (40) begin
      @(negedge aclk);
      at = awvalid && awready;
      wt = wvalid && wready;
      bt = bvalid;
      r = bresp;
      @(posedge aclk);
      if (at) awvalid <= 1'h0;
      if (wt) wvalid <= 1'h0;
      if (bt) begin
        bready <= 1'h0;
        chk({30'h0, r}, {30'h0, er});
        return;
      end
    end
    mismatches++;
    tally_and_finish;
  endtask
  // Read one word and compare data and response code
  task automatic rd(input logic [7:0] a, input logic [31:0] exp, input logic [1:0] er = 2'h0);
    logic at, rt;
    logic [31:0] d;
    logic [1:0] r;
    @(posedge aclk);
    araddr <= a;
    arvalid <= 1'h1;
    rready <= 1'h1;
    repeat (40) begin
      @(negedge aclk);
      at = arvalid && arready;
      rt = rvalid;
      d = rdata;
      r = rresp;
      @(posedge aclk);
      if (at) arvalid <= 1'h0;
      if (rt) begin
        rready <= 1'h0;
        chk(d, exp);
        chk({30'h0, r}, {30'h0, er});
        return;
      end
    end
    mismatches++;
    tally_and_finish;
  endtask
  task automatic settle(input int k);
    repeat (k) @(posedge aclk);
    @(negedge aclk);
  endtask
  // ********************
  // Main sequence
  // ********************
  initial begin
    repeat (12) @(posedge aclk);
    aresetn <= 1'h1;
    foreach (ra[i]) rd(ra[i], 32'h0);
    rd(8'h20, 32'h0, 2'h2);
    wr(8'h20, 32'hff, 2'h2);
    wr(8'h00, 32'hffff_ffff);
    rd(8'h00, 32'hbf);
    chk({24'h0, eff}, 32'hbf);
    wr(8'h00, 32'h0, 2'h0, 4'h0);
    rd(8'h00, 32'hbf);
    wr(8'h0c, 32'h1);
    rd(8'h00, 32'hff);
    // Each enable except bit 1 gates its own event only
    for (int i = 0; i < 8; i++) begin
      if (i == 1) continue;
      wr(8'h00, 32'h1 << i);
      ev <= 8'h01 << i;
      settle(2);
      chk({31'h0, irq}, 32'h1);
      @(posedge aclk);
      ev <= ~(8'h01 << i);
      settle(2);
      chk({31'h0, irq}, 32'h0);
    end
    rd(8'h10, 32'h7d);
    @(posedge aclk);
    ev <= 8'h00;
    // Error flags one source at a time, device mode
    wr(8'h0c, 32'h0);
    wr(8'h08, 32'hffff_ffff);
    rd(8'h08, 32'hbf);
    wr(8'h00, 32'h2);
    for (int k = 0; k < 7; k++) begin
      if (k == 1) continue;
      eng_u.hit(uier_err_in_t'(7'h01 << k));
      rd(8'h04, {24'h0, fb[k]});
      chk({30'h0, summ, irq}, 32'h3);
      wr(8'h04, {24'h0, fb[k]});
      rd(8'h04, 32'h0);
    end
    wr(8'h08, 32'hbd);
    eng_u.hit(uier_err_in_t'(7'h04));
    rd(8'h04, 32'h2);
    chk({31'h0, summ}, 32'h0);
    wr(8'h04, 32'h2);
    // Host mode end-of-frame error and a partial clear
    wr(8'h0c, 32'h1);
    eng_u.hit(uier_err_in_t'(7'h42));
    rd(8'h04, 32'h82);
    wr(8'h04, 32'h02);
    rd(8'h04, 32'h80);
    wr(8'h04, 32'h80);
    // Received byte beyond the descriptor count
    @(posedge aclk);
    strobe <= 1'h1;
    idx <= 10'h3;
    cnt <= 10'h4;
    settle(0);
    chk({31'h0, rxok}, 32'h1);
    @(posedge aclk);
    idx <= 10'h4;
    settle(0);
    chk({31'h0, rxok}, 32'h0);
    @(posedge aclk);
    strobe <= 1'h0;
    rd(8'h04, 32'h20);
    // Endpoint registers, host mode then device mode
    for (int n = 0; n < 16; n++) wr(8'h40 + 8'(4 * n), 32'hffff_fffd);
    for (int n = 0; n < 16; n++) rd(8'h40 + 8'(4 * n), (n == 0) ? 32'hdd : 32'h1d);
    chk({30'h0, lsd, nrd}, 32'h3);
    wr(8'h0c, 32'h0);
    rd(8'h40, 32'h1d);
    chk({30'h0, lsd, nrd}, 32'h0);
    // Lookup of endpoint 3 for four enable combinations
    sel <= 4'h3;
    foreach (epv[i]) begin
      wr(8'h4c, {24'h0, epv[i]});
      settle(2);
      chk({28'h0, okrx, oktx, oksu, hs}, {28'h0, epx[i]});
    end
    eng_u.stall(4'h5);
    rd(8'h54, 32'h1f);
    tally_and_finish;
  end
endmodule
bind uier_regs uier_regs_properties chk_u (.aclk(aclk), .aresetn(aresetn),
  .s_axi_awvalid(s_axi_awvalid), .s_axi_awready(s_axi_awready),
  .s_axi_wvalid(s_axi_wvalid), .s_axi_wready(s_axi_wready), .s_axi_bvalid(s_axi_bvalid),
  .s_axi_bready(s_axi_bready),
  .s_axi_arvalid(s_axi_arvalid), .s_axi_arready(s_axi_arready),
  .s_axi_rvalid(s_axi_rvalid), .rx_byte_strobe(rx_byte_strobe),
  .rx_byte_index(rx_byte_index), .bd_byte_count(bd_byte_count),
  .rx_store_enable(rx_store_enable), .ep_rx_allowed(ep_rx_allowed),
  .ep_tx_allowed(ep_tx_allowed), .ep_setup_allowed(ep_setup_allowed),
  .event_flags(event_flags), .event_enable_eff(event_enable_eff),
  .error_summary_flag(error_summary_flag), .usb_irq(usb_irq));
`default_nettype wire

// file: uier_regs_properties.sv
/*
 Port checker for the USB register bank.
 Assumes a bind to uier_regs on one clock with synchronous active-low reset.
*/
`timescale 1ns/1ps
`default_nettype none
module uier_regs_properties (
  input wire logic aclk,
  input wire logic aresetn,
  input wire logic s_axi_awvalid,
  input wire logic s_axi_awready,
  input wire logic s_axi_wvalid,
  input wire logic s_axi_wready,
  input wire logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic s_axi_arvalid,
  input wire logic s_axi_arready,
  input wire logic s_axi_rvalid,
  input wire logic rx_byte_strobe,
  input wire logic [9:0] rx_byte_index,
  input wire logic [9:0] bd_byte_count,
  input wire logic rx_store_enable,
  input wire logic ep_rx_allowed,
  input wire logic ep_tx_allowed,
  input wire logic ep_setup_allowed,
  input wire logic [7:0] event_flags,
  input wire logic [7:0] event_enable_eff,
  input wire logic error_summary_flag,
  input wire logic usb_irq
);
  // ********************
  // Port relations
  // ********************
  logic irq_cause;
  // Event vector with the summary in place of bit 1, gated by enables
  assign irq_cause = |({event_flags[7:2], error_summary_flag, event_flags[0]} & event_enable_eff);
  default clocking dc @(posedge aclk); endclocking
  default disable iff (!aresetn);
  store_gate_a:
  assert property (rx_store_enable == (rx_byte_strobe && (rx_byte_index < bd_byte_count)))
    else $error("store enable wrong");
  setup_pair_a:
  assert property (ep_setup_allowed |-> ep_rx_allowed && ep_tx_allowed)
    else $error("setup allowed without both directions");
  irq_level_a:
  assert property (1'h1 |=> usb_irq == $past(irq_cause))
    else $error("interrupt request wrong");
  summary_irq_a:
  assert property (error_summary_flag && event_enable_eff[1] |=> usb_irq)
    else $error("enabled summary gave no request");
  write_answer_a:
  assert property (s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready
    |-> ##[1:2] s_axi_bvalid) else $error("write response late");
  read_answer_a:
  assert property (s_axi_arvalid && s_axi_arready |-> ##2 s_axi_rvalid)
    else $error("read data late");
  write_stand_a:
  assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid)
    else $error("write response dropped early");
  read_block_a:
  assert property (s_axi_rvalid |-> !s_axi_arready)
    else $error("read taken during response");
  irq_seen_c: cover property ($rose(usb_irq));
  summary_seen_c: cover property ($rose(error_summary_flag));
  setup_seen_c: cover property (ep_setup_allowed);
endmodule
`default_nettype wire
